// ---- rtl/ipnm_pkg.sv ----
// Constants shared by the interrupt priority, nesting and mask block
package ipnm_pkg;
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int unsigned NUM_SRC = 15;
    localparam int unsigned SRC_IDX_W = 4;
    localparam int unsigned NUM_LVL = 7;

    typedef logic [2:0] ipnm_level_t;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PEND = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_INSV = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned MODE_SEL_BIT = 0;
    localparam int unsigned MODE_ET7_BIT = 1;
    localparam int unsigned MODE_ET6_BIT = 2;
    localparam int unsigned MODE_ET1_BIT = 3;
    localparam int unsigned MODE_W = 4;
    localparam int unsigned STAT_LVL_LSB = 0;
    localparam int unsigned STAT_SRC_LSB = 4;
    localparam int unsigned STAT_SRCV_BIT = 8;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [14:0] SRC_RST = 15'h0000;

    // Sources that merge several peripheral events
    localparam logic [14:0] MULTI_EVENT_DEF = 15'h30b4;

    // ----------------------------------------------------------------
    // Priority levels
    // ----------------------------------------------------------------
    localparam ipnm_level_t LVL_NONE = 3'h0;
    localparam ipnm_level_t LVL_ONE = 3'h1;
    localparam ipnm_level_t LVL_INT = 3'h4;
    localparam ipnm_level_t LVL_SIX = 3'h6;
    localparam ipnm_level_t LVL_SEVEN = 3'h7;

    // ----------------------------------------------------------------
    // Internal source index, index 0 ranks highest
    // ----------------------------------------------------------------
    localparam int unsigned SRC_GENERAL_PIN_ELEVEN = 0;
    localparam int unsigned SRC_GENERAL_PIN_TEN = 1;
    localparam int unsigned SRC_SERIAL_CHANNEL_ONE = 2;
    localparam int unsigned SRC_SERIAL_DMA_BUS_ERROR = 3;
    localparam int unsigned SRC_GENERAL_DMA = 4;
    localparam int unsigned SRC_SERIAL_CHANNEL_TWO = 5;
    localparam int unsigned SRC_TIMER_ONE = 6;
    localparam int unsigned SRC_SERIAL_CHANNEL_THREE = 7;
    localparam int unsigned SRC_GENERAL_PIN_NINE = 8;
    localparam int unsigned SRC_TIMER_TWO = 9;
    localparam int unsigned SRC_SERIAL_CONTROL_PORT = 10;
    localparam int unsigned SRC_TIMER_THREE = 11;
    localparam int unsigned SRC_MANAGEMENT_CHANNEL_ONE = 12;
    localparam int unsigned SRC_MANAGEMENT_CHANNEL_TWO = 13;
    localparam int unsigned SRC_GENERAL_PIN_EIGHT = 14;
endpackage

// ---- rtl/ipnm_first_set.sv ----
// Fixed-priority picker: lowest set index wins
`timescale 1ns/1ps
`default_nettype none
module ipnm_first_set #(
    parameter int unsigned N = 15,
    parameter int unsigned W = 4
) (
    // Requests, index 0 highest
    input wire logic [N-1:0] req,
    // Winner
    output logic [W-1:0] idx,
    output logic valid
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    initial begin
        if (N < 1 || (1 << W) < N) begin
            $error("ipnm_first_set: index width too small");
        end
    end

    // Scan downward so the lowest set index is kept last
    always_comb begin
        idx = '0;
        valid = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = W'(i);
                valid = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ipnm_core.sv ----
// Interrupt priority, nesting and masking logic with APB registers
//
// Function
// - Seven levels, seven highest; internal sources at level four, never external.
// - Normal mode accepts external requests on all six non-four levels.
// - Dedicated mode: external requests only at levels seven, six, one.
// - Fifteen internal sources ranked in fixed order inside level four.
// - General DMA source carries only the general-purpose channel.
// - Only the highest eligible pending request goes to the core.
// - Acknowledged internal request clears its pending bit.
// - After each acknowledge the next winner is presented.
// - Internal acknowledge sets that source's in-service bit.
// - In-service bit blocks its source and all lower ranked ones.
// - Blocked sources still record events as pending.
// - Per-source mask bit keeps a source from requesting.
// - Masked source still sets its pending bit for polling.
// - Peripheral-masked event neither requests nor sets pending.
// - Masking an event while pending clears the pending bit.
// - Clearing all unmasked events clears the pending bit.
// - Each dedicated line selectable edge or level triggered.
// - Winner level goes to core on separate internal level lines.
// - Mode bit zero selects encoded lines, one dedicated lines.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ipnm_core
    import ipnm_pkg::*;
#(
    parameter int unsigned NSRC = ipnm_pkg::NUM_SRC,
    parameter logic [14:0] MULTI_EVENT = ipnm_pkg::MULTI_EVENT_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External request pins, active low
    input wire logic [2:0] encoded_priority_lines_n,
    // Internal sources: event pulse and live unmasked-event level
    input wire logic [14:0] src_event,
    input wire logic [14:0] src_event_live,
    // Core side
    output logic [2:0] core_level,
    input wire logic core_ack,
    input wire logic [2:0] core_ack_level,
    output logic [3:0] ack_source,
    output logic ack_source_valid
);
    import ipnm_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    initial begin
        if (NSRC != NUM_SRC) begin
            $error("ipnm_core: source count must be 15");
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [MODE_W-1:0] mode_r, mode_nxt;
    logic [14:0] pending_bits_r, pending_bits_nxt;
    logic [14:0] source_mask_bits_r, source_mask_bits_nxt;
    logic [14:0] in_service_bits_r, in_service_bits_nxt;
    logic [2:0] edge_flag_r, edge_flag_nxt;
    logic [2:0] pins_prev_r, pins_prev_nxt;
    ipnm_level_t core_level_r, core_level_nxt;
    logic [3:0] ack_source_r, ack_source_nxt;
    logic ack_source_valid_r, ack_source_valid_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    logic wr_en, setup, hit;
    logic request_pin_mode_select;
    logic dedicated_request_level_seven;
    logic dedicated_request_level_six;
    logic dedicated_request_level_one;
    logic [7:0] external_request;
    logic [14:0] blocked, set_eff, internal_request;
    logic [3:0] int_idx;
    logic int_any;
    logic [6:0] by_rank;
    logic [2:0] rank_idx;
    logic rank_any;
    logic ack_int;

    // ----------------------------------------------------------------
    // APB decode; always ready, so every access is one access cycle
    // ----------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign hit = (paddr == OFS_MODE) | (paddr == OFS_PEND) | (paddr == OFS_MASK)
        | (paddr == OFS_INSV) | (paddr == OFS_STAT);
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_r;

    // ----------------------------------------------------------------
    // External requests
    // ----------------------------------------------------------------
    // mode bit picks pin meaning
    assign request_pin_mode_select = mode_r[MODE_SEL_BIT];
    assign dedicated_request_level_seven = ~encoded_priority_lines_n[2];
    assign dedicated_request_level_six = ~encoded_priority_lines_n[1];
    assign dedicated_request_level_one = ~encoded_priority_lines_n[0];

    // Edge latch per dedicated line; cleared when the core takes that level
    always_comb begin
        pins_prev_nxt = encoded_priority_lines_n;
        edge_flag_nxt = edge_flag_r;
        if (core_ack && core_ack_level == LVL_SEVEN) begin
            edge_flag_nxt[2] = 1'b0;
        end
        if (core_ack && core_ack_level == LVL_SIX) begin
            edge_flag_nxt[1] = 1'b0;
        end
        if (core_ack && core_ack_level == LVL_ONE) begin
            edge_flag_nxt[0] = 1'b0;
        end
        // A new falling edge wins over the clear
        edge_flag_nxt = edge_flag_nxt | (pins_prev_r & ~encoded_priority_lines_n);
        if (!request_pin_mode_select) begin
            edge_flag_nxt = 3'h0;
        end
        // a line in level mode keeps no stale edge for a later switch to edge mode
        edge_flag_nxt = edge_flag_nxt & {mode_r[MODE_ET7_BIT], mode_r[MODE_ET6_BIT],
            mode_r[MODE_ET1_BIT]};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pins_prev_r <= 3'h7;
            edge_flag_r <= 3'h0;
        end else begin
            pins_prev_r <= pins_prev_nxt;
            edge_flag_r <= edge_flag_nxt;
        end
    end

    // Level-per-bit external request map, bit n is level n
    always_comb begin
        external_request = 8'h00;
        if (!request_pin_mode_select) begin
            external_request[~encoded_priority_lines_n] = 1'b1;
        end else begin
            // only seven, six and one exist
            external_request[7] = mode_r[MODE_ET7_BIT] ? edge_flag_r[2]
                : dedicated_request_level_seven;
            external_request[6] = mode_r[MODE_ET6_BIT] ? edge_flag_r[1]
                : dedicated_request_level_six;
            external_request[1] = mode_r[MODE_ET1_BIT] ? edge_flag_r[0]
                : dedicated_request_level_one;
        end
        // level four never external; zero means no request
        external_request[4] = 1'b0;
        external_request[0] = 1'b0;
    end

    // ----------------------------------------------------------------
    // Internal sources
    // ----------------------------------------------------------------
    // a set in-service bit blocks itself and everything ranked below
    generate
        for (genvar g = 0; g < 15; g++) begin : g_blk
            if (g == 0) begin : g_first
                assign blocked[g] = in_service_bits_r[g];
            end else begin : g_rest
                assign blocked[g] = blocked[g-1] | in_service_bits_r[g];
            end
        end
    endgenerate

    assign internal_request = pending_bits_r & source_mask_bits_r & ~blocked;
    // bit four is the general DMA channel only; serial DMA errors use bit three
    // peripheral-masked events of merged sources never set pending
    assign set_eff = src_event & (src_event_live | ~MULTI_EVENT);

    ipnm_first_set #(.N(15), .W(4)) u_int_pick (
        .req(internal_request),
        .idx(int_idx),
        .valid(int_any)
    );

    // level-ranked vector: rank k is level 7-k, level four internal
    assign by_rank = {external_request[1], external_request[2], external_request[3],
        int_any, external_request[5], external_request[6], external_request[7]};

    ipnm_first_set #(.N(7), .W(3)) u_lvl_pick (
        .req(by_rank),
        .idx(rank_idx),
        .valid(rank_any)
    );

    assign ack_int = core_ack && core_ack_level == LVL_INT && int_any;

    // ----------------------------------------------------------------
    // Registers: mode, mask, pending and in-service
    // ----------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        source_mask_bits_nxt = source_mask_bits_r;
        pending_bits_nxt = pending_bits_r;
        in_service_bits_nxt = in_service_bits_r;
        if (wr_en && paddr == OFS_MODE) begin
            mode_nxt = pwdata[MODE_W-1:0];
        end
        if (wr_en && paddr == OFS_MASK) begin
            source_mask_bits_nxt = pwdata[14:0];
        end
        // Write one to clear, for polled service
        if (wr_en && paddr == OFS_PEND) begin
            pending_bits_nxt = pending_bits_nxt & ~pwdata[14:0];
        end
        // software ends service by clearing in-service
        if (wr_en && paddr == OFS_INSV) begin
            in_service_bits_nxt = in_service_bits_nxt & ~pwdata[14:0];
        end
        // merged source drops pending once no unmasked event stands
        pending_bits_nxt = pending_bits_nxt & (src_event_live | ~MULTI_EVENT);
        if (ack_int) begin
            pending_bits_nxt[int_idx] = 1'b0;
            in_service_bits_nxt[int_idx] = 1'b1;
        end
        // new events recorded unless peripheral-masked at a merged source, and win over any clear
        pending_bits_nxt = pending_bits_nxt | set_eff;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_r <= MODE_RST;
            source_mask_bits_r <= SRC_RST;
            pending_bits_r <= SRC_RST;
            in_service_bits_r <= SRC_RST;
        end else begin
            mode_r <= mode_nxt;
            source_mask_bits_r <= source_mask_bits_nxt;
            pending_bits_r <= pending_bits_nxt;
            in_service_bits_r <= in_service_bits_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Core outputs and read data
    // ----------------------------------------------------------------
    always_comb begin
        // re-evaluated every cycle, so the next winner follows an ack
        core_level_nxt = rank_any ? ipnm_level_t'(3'h7 - rank_idx) : LVL_NONE;
        ack_source_nxt = ack_source_r;
        ack_source_valid_nxt = ack_source_valid_r;
        if (core_ack) begin
            ack_source_nxt = ack_int ? int_idx : 4'h0;
            ack_source_valid_nxt = ack_int;
        end
        prdata_nxt = prdata_r;
        // Captured in setup so read data comes from a flop
        if (setup) begin
            case (paddr)
                OFS_MODE: prdata_nxt = {28'h0, mode_r};
                OFS_PEND: prdata_nxt = {17'h0, pending_bits_r};
                OFS_MASK: prdata_nxt = {17'h0, source_mask_bits_r};
                OFS_INSV: prdata_nxt = {17'h0, in_service_bits_r};
                OFS_STAT: prdata_nxt = {23'h0, int_any, int_idx, 1'b0,
                    core_level_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_level_r <= LVL_NONE;
            ack_source_r <= 4'h0;
            ack_source_valid_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            core_level_r <= core_level_nxt;
            ack_source_r <= ack_source_nxt;
            ack_source_valid_r <= ack_source_valid_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign core_level = core_level_r;
    assign ack_source = ack_source_r;
    assign ack_source_valid = ack_source_valid_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_int_ack;
        core_ack && core_ack_level == LVL_INT && int_any;
    endsequence

    sequence s_only_int;
        int_any && external_request[7:5] == 3'h0;
    endsequence

    a_int_at_four: assert property (@(posedge ref_clk) disable iff (rst)
        s_only_int |=> core_level_r == LVL_INT)
        else $error("internal request not shown at level four");

    a_no_ext_four: assert property (@(posedge ref_clk) disable iff (rst)
        !request_pin_mode_select && encoded_priority_lines_n == 3'h3 && !int_any
        |=> core_level_r == LVL_NONE)
        else $error("external level four accepted");

    a_ded_one: assert property (@(posedge ref_clk) disable iff (rst)
        request_pin_mode_select && !mode_r[MODE_ET1_BIT] && dedicated_request_level_one
        && !dedicated_request_level_seven && !dedicated_request_level_six && !int_any
        |=> core_level_r == LVL_ONE)
        else $error("dedicated level one not presented");

    a_ack_clears: assert property (@(posedge ref_clk) disable iff (rst)
        s_int_ack ##1 !$past(set_eff[int_idx]) |-> !pending_bits_r[$past(int_idx)])
        else $error("pending not cleared by acknowledge");

    a_ack_service: assert property (@(posedge ref_clk) disable iff (rst)
        s_int_ack |=> in_service_bits_r[$past(int_idx)] && ack_source_valid_r)
        else $error("in-service not set by acknowledge");

    a_top_blocks: assert property (@(posedge ref_clk) disable iff (rst)
        in_service_bits_r[0] && external_request == 8'h00 |=> core_level_r == LVL_NONE)
        else $error("blocked source reached the core");

    a_event_held: assert property (@(posedge ref_clk) disable iff (rst)
        (src_event & ~MULTI_EVENT) != 15'h0
        |=> (pending_bits_r & $past(src_event & ~MULTI_EVENT))
            == $past(src_event & ~MULTI_EVENT))
        else $error("event not recorded as pending");

    a_merged_drop: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (pending_bits_r & MULTI_EVENT & ~$past(src_event_live)) == 15'h0)
        else $error("merged source pending without live event");

    a_idle_zero: assert property (@(posedge ref_clk) disable iff (rst)
        external_request == 8'h00 && (pending_bits_r & source_mask_bits_r) == 15'h0
        |=> core_level_r == LVL_NONE)
        else $error("level shown with nothing eligible");
endmodule
`default_nettype wire

// ---- verification/ipnm_far_model.sv ----
// Far-side model: interrupting device pins and core acknowledge
`timescale 1ns/1ps
`default_nettype none
module ipnm_far_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bench controls
    input wire logic dedicated,
    input wire logic arm,
    input wire logic [2:0] ext_lvl,
    input wire logic [2:0] core_mask,
    // Block side
    output logic [2:0] pins_n,
    input wire logic [2:0] core_level,
    output logic core_ack,
    output logic [2:0] core_ack_level
);
    logic armed_r;
    logic take;
    // ----
    // External device
    // ----
    // pin encoding
    // The device masks and withdraws its own request; zero means released
    always_comb begin
        if (dedicated) begin
            pins_n = ~{ext_lvl == 3'h7, ext_lvl == 3'h6, ext_lvl == 3'h1};
        end else begin
            pins_n = ~ext_lvl;
        end
    end
    // ----
    // Core
    // ----
    // mask, seven nonmaskable
    assign take = armed_r && core_level != 3'h0 && (core_level > core_mask || core_level == 3'h7);
    // One acknowledge per arm; level lines toggle when idle so nothing stale looks valid
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
            core_ack <= 1'b0;
            core_ack_level <= 3'h0;
        end else begin
            armed_r <= (armed_r || arm) && !take;
            core_ack <= take;
            core_ack_level <= take ? core_level : ~core_ack_level;
        end
    end
endmodule
`default_nettype wire

// ---- verification/ipnm_core_bench.sv ----
// Self-checking bench for the interrupt priority, nesting and mask block
`timescale 1ns/1ps
`default_nettype none
module ipnm_core_bench;
    import ipnm_pkg::*;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, core_ack, ack_source_valid;
    logic arm, dedicated, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] pins_n, core_level, core_ack_level, ext_lvl, core_mask;
    logic [14:0] src_event, src_event_live;
    logic [3:0] ack_source;
    logic [2:0] lv [6] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1};
    int bad_count, cmp_count;

    ipnm_core dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .encoded_priority_lines_n(pins_n), .src_event(src_event),
        .src_event_live(src_event_live), .core_level(core_level), .core_ack(core_ack),
        .core_ack_level(core_ack_level), .ack_source(ack_source),
        .ack_source_valid(ack_source_valid));
    ipnm_far_model far (.ref_clk(ref_clk), .rst(rst), .dedicated(dedicated), .arm(arm),
        .ext_lvl(ext_lvl), .core_mask(core_mask), .pins_n(pins_n), .core_level(core_level),
        .core_ack(core_ack), .core_ack_level(core_ack_level));

    // Free-running 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Outputs are sampled on the falling edge, well after registers settle
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // Whole APB transfer; the request is held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic cl(input logic [2:0] e);
        chk("core_level", {29'h0, e}, {29'h0, core_level});
    endtask
    task automatic ev(input logic [14:0] m);
        @(posedge ref_clk);
        src_event <= m;
        @(posedge ref_clk);
        src_event <= 15'h0;
        tk(2);
    endtask
    task automatic xl(input logic [2:0] l);
        @(posedge ref_clk);
        ext_lvl <= l;
        tk(2);
    endtask
    // Arm the core model once; ack source and next level land within four edges
    task automatic ack(input logic [3:0] s, input logic v);
        @(posedge ref_clk);
        arm <= 1'b1;
        @(posedge ref_clk);
        arm <= 1'b0;
        tk(4);
        chk("ack_source_valid", {31'h0, v}, {31'h0, ack_source_valid});
        if (v) chk("ack_source", {28'h0, s}, {28'h0, ack_source});
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rd("mode", OFS_MODE, 32'h0);
        rd("pend", OFS_PEND, 32'h0);
        rd("mask", OFS_MASK, 32'h0);
        rd("insv", OFS_INSV, 32'h0);
        cl(LVL_NONE);
        rd("unmapped", 8'h14, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
    endtask
    task automatic t_mask;
        ev(15'h1 << SRC_TIMER_TWO);
        rd("pend", OFS_PEND, 32'h1 << SRC_TIMER_TWO);
        cl(LVL_NONE);
        apb(1'b1, OFS_MASK, 32'h7fff);
        tk(2);
        cl(LVL_INT);
        q = 32'(1 << STAT_SRCV_BIT | SRC_TIMER_TWO << STAT_SRC_LSB | LVL_INT << STAT_LVL_LSB);
        rd("stat", OFS_STAT, q);
        apb(1'b1, OFS_PEND, 32'h1 << SRC_TIMER_TWO);
        tk(2);
        cl(LVL_NONE);
    endtask
    task automatic t_rank;
        ev(15'h7fff);
        for (int i = 0; i < 15; i++) begin
            ack(4'(i), 1'b1);
            rd("insv", OFS_INSV, 32'h1 << i);
            apb(1'b1, OFS_INSV, 32'h1 << i);
        end
        rd("pend", OFS_PEND, 32'h0);
        cl(LVL_NONE);
    endtask
    task automatic t_nest;
        ev(15'h4040);
        ack(4'h6, 1'b1);
        cl(LVL_NONE);
        rd("pend", OFS_PEND, 32'h4000);
        ev(15'h0001);
        cl(LVL_INT);
        ack(4'h0, 1'b1);
        apb(1'b1, OFS_INSV, 32'h0041);
        tk(2);
        cl(LVL_INT);
        ack(4'he, 1'b1);
        apb(1'b1, OFS_INSV, 32'h4000);
    endtask
    task automatic t_ext;
        foreach (lv[i]) begin
            xl(lv[i]);
            cl(lv[i]);
        end
        xl(LVL_INT);
        cl(LVL_NONE);
        ev(15'h0002);
        xl(3'h5);
        cl(3'h5);
        xl(3'h3);
        cl(LVL_INT);
        xl(3'h0);
        apb(1'b1, OFS_PEND, 32'h2);
        tk(2);
        cl(LVL_NONE);
    endtask
    task automatic t_ded;
        apb(1'b1, OFS_MODE, 32'h1);
        dedicated <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            xl(lv[i]);
            cl((lv[i] == 3'h5 || lv[i] < 3'h4) && lv[i] != 3'h1 ? LVL_NONE : lv[i]);
        end
        xl(3'h0);
        cl(LVL_NONE);
        apb(1'b1, OFS_MODE, 32'hf);
        tk(1);
        cl(LVL_NONE);
        xl(LVL_ONE);
        xl(LVL_SEVEN);
        xl(3'h0);
        cl(LVL_SEVEN);
        core_mask <= 3'h7;
        ack(4'h0, 1'b0);
        cl(LVL_ONE);
        xl(LVL_SIX);
        xl(3'h0);
        cl(LVL_SIX);
        core_mask <= 3'h3;
        ack(4'h0, 1'b0);
        cl(LVL_ONE);
        apb(1'b1, OFS_MODE, 32'h0);
        tk(1);
        cl(LVL_NONE);
        dedicated <= 1'b0;
    endtask
    task automatic t_multi;
        @(posedge ref_clk);
        src_event_live[SRC_SERIAL_CHANNEL_TWO] <= 1'b0;
        ev(15'h1 << SRC_SERIAL_CHANNEL_TWO);
        rd("pend", OFS_PEND, 32'h0);
        @(posedge ref_clk);
        src_event_live <= 15'h7fff;
        ev(15'h1 << SRC_SERIAL_CHANNEL_TWO);
        rd("pend", OFS_PEND, 32'h1 << SRC_SERIAL_CHANNEL_TWO);
        @(posedge ref_clk);
        src_event_live[SRC_SERIAL_CHANNEL_TWO] <= 1'b0;
        rd("pend", OFS_PEND, 32'h0);
        cl(LVL_NONE);
    endtask
    // ----
    // Run control
    // ----
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence after sixteen cycles of reset
    initial begin
        {rst, arm, dedicated} = 3'b100;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {src_event, ext_lvl, core_mask} = {15'h0, 3'h0, 3'h3};
        src_event_live = 15'h7fff;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_mask;
        t_rank;
        t_nest;
        t_ext;
        t_ded;
        t_multi;
        wrap_up;
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
